/* rtl/ilo_pkg.sv */
// Constants, types and address helper for the indexed literal offset decoder
// Contract
// RULE_01: Enabled extension remaps small access operands to pointer offsets
// RULE_02: Indexed add sums accumulator and byte at pointer+k
// RULE_03: Indexed add opcode is 0010 01d0 kkkk kkkk
// RULE_04: Destination bit 0 writes accumulator, 1 writes memory
// RULE_05: Indexed add updates all five status flags
// RULE_06: Bit-set sets bit b, flags untouched
// RULE_07: Set-all writes FFh, flags untouched
// RULE_08: One word, four phases: decode, read, process, write
// RULE_09: Extension enable resets to zero; software must set it
// RULE_10: Disabled extension uses literal access or banked addresses
// RULE_11: Remap only when enabled, access bit 0, operand <=5Fh
// RULE_12: Effective address is pointer plus offset, pointer unchanged
package ilo_pkg;
   // Register byte offsets
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_BASE     = 8'h04;
   localparam logic [7:0]  OFF_BANK     = 8'h08;
   localparam logic [7:0]  OFF_ACC      = 8'h0C;
   localparam logic [7:0]  OFF_STATUS   = 8'h10;
   localparam logic [7:0]  OFF_INSTR    = 8'h14;
   // Field positions
   localparam int          CTRL_EXT_EN  = 0;
   localparam int          FLAG_C       = 0;
   localparam int          FLAG_DIGIT   = 1;
   localparam int          FLAG_Z       = 2;
   localparam int          FLAG_OVER    = 3;
   localparam int          FLAG_N       = 4;
   localparam int          STAT_BUSY    = 8;
   localparam int          STAT_ILLEGAL = 9;
   // Reset values
   localparam logic        RST_EXT_EN   = 1'b0;
   localparam logic [11:0] RST_BASE     = 12'h000;
   localparam logic [3:0]  RST_BANK     = 4'h0;
   localparam logic [7:0]  RST_ACC      = 8'h00;
   localparam logic [4:0]  RST_FLAGS    = 5'h00;
   localparam logic [15:0] RST_INSTR    = 16'h0000;
   // Addressing constants and set-all value
   localparam logic [7:0]  REMAP_MAX    = 8'h5F;
   localparam logic [3:0]  ACCESS_HI    = 4'hF;
   localparam logic [3:0]  ACCESS_LO    = 4'h0;
   localparam logic [7:0]  SET_ALL      = 8'hFF;
   // Opcode patterns (upper byte prefixes)
   localparam logic [5:0]  OPC_ADD      = 6'h09;
   localparam logic [3:0]  OPC_BIT_SET  = 4'h8;
   localparam logic [6:0]  OPC_SET_ALL  = 7'h34;

   // Phase of one instruction cycle
   typedef enum logic [2:0] {Q_IDLE, Q_DECODE, Q_READ, Q_PROCESS, Q_WRITE} ilo_phase_t;
   // Decoded operation
   typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_BIT_SET, OP_SET_ALL} ilo_op_t;

   // Effective data address from mode, access bit, operand, pointer and bank
   function automatic logic [11:0] ilo_eff_addr(input logic ext_en, input logic acc_bit,
                                                input logic [7:0] f, input logic [11:0] base,
                                                input logic [3:0] bank);
      logic [11:0] addr;
      addr = {bank, f};
      if (!acc_bit)
      begin
         // RULE_01 pointer plus offset
         if (ext_en && f <= REMAP_MAX)
            addr = 12'(base + {4'h0, f});
         else if (f <= REMAP_MAX)
            addr = {ACCESS_LO, f};
         else
            addr = {ACCESS_HI, f};
      end
      return addr;
   endfunction : ilo_eff_addr
endpackage : ilo_pkg

/* rtl/ilo_alu_if.sv */
// Carrier between the sequencer and the data processing unit
`timescale 1ns/1ps
`default_nettype none
interface ilo_alu_if;
   import ilo_pkg::*;
   ilo_op_t    op;        // Operation to perform
   logic [7:0] acc;       // Accumulator value
   logic [7:0] operand;   // Byte read from memory
   logic [2:0] bit_sel;   // Bit number for bit-set
   logic [7:0] result;    // Processed byte
   logic [4:0] flags;     // Flags produced by add

   modport core (output op, acc, operand, bit_sel, input result, flags);
   modport alu  (input op, acc, operand, bit_sel, output result, flags);
endinterface : ilo_alu_if
`default_nettype wire

/* rtl/ilo_alu.sv */
// Data processing unit: add with flags, bit-set, set-all
`timescale 1ns/1ps
`default_nettype none
module ilo_alu
(
   ilo_alu_if.alu port
);
   import ilo_pkg::*;

   wire [8:0] sum    = {1'b0, port.acc} + {1'b0, port.operand};  // Full sum with carry
   wire [4:0] nib    = {1'b0, port.acc[3:0]} + {1'b0, port.operand[3:0]};  // Low nibble
   wire [7:0] bitmsk = 8'h01 << port.bit_sel;                     // One-hot bit mask

   // Result and flags per operation
   always_comb
   begin
      port.result = port.operand;
      port.flags  = RST_FLAGS;
      case (port.op)
         // RULE_02 accumulator plus byte
         OP_ADD:
         begin
            port.result = sum[7:0];
            // RULE_05 all five flags
            port.flags[FLAG_C]  = sum[8];
            port.flags[FLAG_DIGIT] = nib[4];
            port.flags[FLAG_Z]  = (sum[7:0] == 8'h00);
            port.flags[FLAG_OVER] = (port.acc[7] == port.operand[7]) && (sum[7] != port.acc[7]);
            port.flags[FLAG_N]  = sum[7];
         end
         // RULE_06 set one bit
         OP_BIT_SET: port.result = port.operand | bitmsk;
         // RULE_07 all ones
         OP_SET_ALL: port.result = SET_ALL;
         default: port.result = port.operand;
      endcase
   end
endmodule : ilo_alu
`default_nettype wire

/* rtl/ilo_core.sv */
// Sequencer, APB registers and memory port of the indexed offset decoder
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ilo_core
(
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic [11:0]      MEM_ADDR,
   input  wire logic [7:0]  MEM_RDATA,
   output logic [7:0]       MEM_WDATA,
   output logic             MEM_WE
);
   import ilo_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic            ext_en;     // Extension enable
   logic [11:0]     base_ptr;   // Indexed base pointer
   logic [3:0]      bank_sel;   // Bank select
   logic [7:0]      acc;        // Accumulator
   logic [4:0]      flags;      // Negative, overflow, zero, digit, carry
   logic            illegal;    // Last opcode not handled
   logic [15:0]     instr;      // Current opcode
   logic [7:0]      operand;    // Byte read in Q2
   logic [7:0]      result;     // Byte processed in Q3
   logic [4:0]      res_flags;  // Flags processed in Q3
   ilo_phase_t      phase;      // Instruction phase
   ilo_op_t         op;         // Decoded operation
   ilo_alu_if       alu_bus ();

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire        busy     = (phase != Q_IDLE);
   wire [7:0]  hi       = instr[15:8];
   wire [7:0]  f_opd    = instr[7:0];
   wire        a_bit    = instr[8];
   wire        d_bit    = instr[9];
   // RULE_03 add pattern, d and a below
   wire        is_add   = (hi[7:2] == OPC_ADD);
   // RULE_06 bit-set pattern
   wire        is_bset  = (hi[7:4] == OPC_BIT_SET);
   // RULE_07 set-all pattern
   wire        is_fill  = (hi[7:1] == OPC_SET_ALL);
   wire        acc_dest = is_add && !d_bit;
   // RULE_01 remap via pointer; RULE_10 and RULE_11 otherwise literal
   wire [11:0] eff_addr = ilo_eff_addr(ext_en, a_bit, f_opd, base_ptr, bank_sel);

   // APB decode
   wire        acc_done = PSEL && PENABLE && PREADY;
   wire        wr       = acc_done && PWRITE;
   wire        hit      = (PADDR == OFF_CTRL) || (PADDR == OFF_BASE) || (PADDR == OFF_BANK)
                       || (PADDR == OFF_ACC) || (PADDR == OFF_STATUS) || (PADDR == OFF_INSTR);
   wire        start    = wr && (PADDR == OFF_INSTR);

   // Writes wait while an instruction runs so state stays coherent
   assign PREADY  = !(PWRITE && busy);
   assign PSLVERR = PSEL && PENABLE && !hit;

   // Read mux
   wire [31:0] rd_mux = (PADDR == OFF_CTRL)   ? {31'h0, ext_en} :
                        (PADDR == OFF_BASE)   ? {20'h0, base_ptr} :
                        (PADDR == OFF_BANK)   ? {28'h0, bank_sel} :
                        (PADDR == OFF_ACC)    ? {24'h0, acc} :
                        (PADDR == OFF_STATUS) ? {22'h0, illegal, busy, 3'h0, flags} :
                        (PADDR == OFF_INSTR)  ? {16'h0, instr} : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // ALU hookup
   assign alu_bus.op      = op;
   assign alu_bus.acc     = acc;
   assign alu_bus.operand = operand;
   assign alu_bus.bit_sel = instr[11:9];
   ilo_alu u_alu (.port(alu_bus));

   ////////////////////////////////////////////////////////////////////////////
   // Phase sequencer
   ilo_phase_t next_phase;
   always_comb
   begin
      next_phase = phase;
      // RULE_08 four phases, one per clock
      case (phase)
         Q_IDLE:    next_phase = start ? Q_DECODE : Q_IDLE;
         Q_DECODE:  next_phase = Q_READ;
         Q_READ:    next_phase = Q_PROCESS;
         Q_PROCESS: next_phase = Q_WRITE;
         Q_WRITE:   next_phase = Q_IDLE;
         default:   next_phase = Q_IDLE;
      endcase
   end

   // Phase register
   always_ff @(posedge CLK)
   begin
      if (SYS_RST) phase <= Q_IDLE;
      else         phase <= next_phase;
   end

   // Software registers
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         // RULE_09 extension off at reset
         ext_en   <= RST_EXT_EN;
         base_ptr <= RST_BASE;
         bank_sel <= RST_BANK;
         instr    <= RST_INSTR;
      end
      else if (wr)
      begin
         if (PADDR == OFF_CTRL)  ext_en   <= PWDATA[CTRL_EXT_EN];
         if (PADDR == OFF_BASE)  base_ptr <= PWDATA[11:0];
         if (PADDR == OFF_BANK)  bank_sel <= PWDATA[3:0];
         if (PADDR == OFF_INSTR) instr    <= PWDATA[15:0];
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)                  PRDATA <= 32'h0000_0000;
      else if (PSEL && !PENABLE)    PRDATA <= rd_mux;
   end

   // Q1 decode and address
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         op       <= OP_NONE;
         illegal  <= 1'b0;
         MEM_ADDR <= 12'h000;
      end
      else if (phase == Q_DECODE)
      begin
         op       <= is_add ? OP_ADD : is_bset ? OP_BIT_SET : is_fill ? OP_SET_ALL : OP_NONE;
         illegal  <= !(is_add || is_bset || is_fill);
         // RULE_12 sum formed, pointer untouched
         MEM_ADDR <= eff_addr;
      end
   end

   // Q2 read, Q3 process
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         operand   <= 8'h00;
         result    <= 8'h00;
         res_flags <= RST_FLAGS;
      end
      else
      begin
         if (phase == Q_READ)    operand   <= MEM_RDATA;
         if (phase == Q_PROCESS) result    <= alu_bus.result;
         if (phase == Q_PROCESS) res_flags <= alu_bus.flags;
      end
   end

   // Q4 write: accumulator or memory, flags only for add
   wire q3_end = (phase == Q_PROCESS) && (op != OP_NONE);
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         acc       <= RST_ACC;
         flags     <= RST_FLAGS;
         MEM_WE    <= 1'b0;
         MEM_WDATA <= 8'h00;
      end
      else
      begin
         // RULE_04 destination select
         MEM_WE    <= q3_end && !(op == OP_ADD && !d_bit);
         MEM_WDATA <= q3_end ? alu_bus.result : MEM_WDATA;
         if (wr && PADDR == OFF_ACC) acc <= PWDATA[7:0];
         else if (q3_end && op == OP_ADD && !d_bit) acc <= alu_bus.result;
         // RULE_05 flags only from add
         if (q3_end && op == OP_ADD) flags <= alu_bus.flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   chk_remap_addr: assert property ( // RULE_01
      phase == Q_READ && ext_en && !a_bit && f_opd <= REMAP_MAX
      |-> MEM_ADDR == 12'(base_ptr + {4'h0, f_opd}))
      else $error("indexed address wrong");
   chk_access_addr: assert property ( // RULE_10
      phase == Q_READ && !ext_en && !a_bit
      |-> MEM_ADDR == {(f_opd <= REMAP_MAX) ? ACCESS_LO : ACCESS_HI, f_opd})
      else $error("access bank address wrong");
   chk_bank_addr: assert property ( // RULE_10
      phase == Q_READ && a_bit |-> MEM_ADDR == {bank_sel, f_opd})
      else $error("banked address wrong");
   chk_high_literal: assert property ( // RULE_11
      phase == Q_READ && ext_en && !a_bit && f_opd > REMAP_MAX |-> MEM_ADDR == {ACCESS_HI, f_opd})
      else $error("high operand remapped");
   chk_add_acc: assert property ( // RULE_04
      phase == Q_PROCESS && op == OP_ADD && !d_bit
      |=> !MEM_WE && acc == 8'($past(acc) + $past(operand)))
      else $error("add to accumulator wrong");
   chk_add_mem: assert property ( // RULE_02
      phase == Q_PROCESS && op == OP_ADD && d_bit
      |=> MEM_WE && MEM_WDATA == 8'($past(acc) + $past(operand)) && $stable(acc))
      else $error("add to memory wrong");
   chk_add_zero: assert property ( // RULE_05
      phase == Q_PROCESS && op == OP_ADD
      |=> flags[FLAG_Z] == (8'($past(acc) + $past(operand)) == 8'h00))
      else $error("zero flag wrong");
   chk_bset_data: assert property ( // RULE_06
      phase == Q_PROCESS && op == OP_BIT_SET
      |=> MEM_WE && MEM_WDATA == ($past(operand) | (8'h01 << instr[11:9])) && $stable(flags))
      else $error("bit set wrong");
   chk_setall_data: assert property ( // RULE_07
      phase == Q_PROCESS && op == OP_SET_ALL |=> MEM_WE && MEM_WDATA == SET_ALL && $stable(flags))
      else $error("set all wrong");
   chk_phase_order: assert property ( // RULE_08
      phase == Q_DECODE |=> phase == Q_READ ##1 phase == Q_PROCESS ##1 phase == Q_WRITE
      ##1 phase == Q_IDLE)
      else $error("phase sequence wrong");
   chk_we_in_q4: assert property ( // RULE_08
      MEM_WE |-> phase == Q_WRITE)
      else $error("write outside fourth phase");
   chk_base_kept: assert property ( // RULE_12
      busy |=> $stable(base_ptr))
      else $error("pointer changed");
   chk_reset_off: assert property (@(posedge CLK) disable iff (1'b0) // RULE_09
      SYS_RST |=> !ext_en)
      else $error("extension enabled after reset");

   cov_add_acc: cover property (phase == Q_PROCESS && op == OP_ADD && !d_bit);
   cov_add_mem: cover property (phase == Q_PROCESS && op == OP_ADD && d_bit && ext_en);
   cov_bset:    cover property (phase == Q_PROCESS && op == OP_BIT_SET && ext_en && !a_bit);
   cov_setall:  cover property (phase == Q_PROCESS && op == OP_SET_ALL);
endmodule : ilo_core
`default_nettype wire

/* bench/ilo_mem_model.sv */
// Data memory model on the far side of the memory port
`timescale 1ns/1ps
`default_nettype none
module ilo_mem_model
(
   input  wire logic        clk,
   input  wire logic [11:0] addr,
   output logic [7:0]       rdata,
   input  wire logic [7:0]  wdata,
   input  wire logic        we
);
   logic [7:0] mem [0:4095];   // Byte store
   ////////////////////////////////////////////////////////////////////////////////
   // Fill with a pattern so no read sees unknowns
   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'hA5 ^ i[7:0];
   end
   // Asynchronous read, ready well inside the read phase
   assign rdata = mem[addr];
   // Write lands at the edge closing the write phase
   always @(posedge clk)
   begin
      if (we)
         mem[addr] <= wdata;
   end
endmodule : ilo_mem_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the indexed offset decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ilo_pkg::*;
   typedef struct {logic [11:0] a; logic [7:0] d; int c;} ilo_note_t;
   logic        clk = 0;                // Bench clock
   logic        rst = 1;                // Reset, high
   logic        psel = 0, pen = 0, pwr = 0;
   logic [7:0]  paddr = 8'h00;          // Bus address
   logic [31:0] pwdata = 32'h0000_0000; // Bus write data
   logic [31:0] prdata;                 // Bus read data
   logic        pready, pslverr, we;    // Answers
   logic [11:0] maddr, base, ea;        // Memory address, pointer
   logic [7:0]  mrd, mwd, k, m, s;      // Memory data, offset, bytes
   logic [2:0]  b;                      // Bit number
   logic [7:0]  acc = 8'h00;            // Accumulator shadow
   logic [4:0]  flg = 5'h00;            // Flag shadow
   logic [31:0] seed = 32'h0000_6fa2;   // Random state
   int          fails = 0, n_checks = 0, cyc = 0, t0 = 0;
   ilo_note_t   wq[$], nt;              // Expected memory writes
   logic [31:0] rq[$];                  // Expected read data
   ////////////////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   ilo_core dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .MEM_ADDR(maddr), .MEM_RDATA(mrd), .MEM_WDATA(mwd), .MEM_WE(we));
   ilo_mem_model mem_i (.clk(clk), .addr(maddr), .rdata(mrd), .wdata(mwd), .we(we));
   ////////////////////////////////////////////////////////////////////////////////
   // Xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   // One bus transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // Read with expected word noted
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd
   // Start an instruction, note its write, wait till idle
   task automatic run(input logic [15:0] op, input logic [11:0] a, input logic [7:0] d,
                      input logic w);
      apb(1'b1, OFF_INSTR, {16'h0000, op});
      if (w)
         wq.push_back('{a, d, cyc + 4});
      repeat (5) @(posedge clk);
   endtask : run
   // Expected sum and flags of an add
   task automatic addx(input logic [7:0] v, output logic [7:0] r);
      logic [8:0] t;
      logic [4:0] h;
      t = {1'b0, acc} + {1'b0, v};
      h = {1'b0, acc[3:0]} + {1'b0, v[3:0]};
      r = t[7:0];
      flg = {t[7], (acc[7] == v[7]) && (t[7] != acc[7]), t[7:0] == 8'h00, h[4], t[8]};
   endtask : addx
   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: memory writes and read data against the notes
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (we === 1'b1)
      begin
         // Unexpected write meets an impossible note
         if (wq.size() > 0)
            nt = wq.pop_front();
         else
            nt = '{12'hFFF, 8'h00, -1};
         check({12'h000, maddr, mwd}, {12'h000, nt.a, nt.d}); // address
         check(cyc, nt.c); // write phase
      end
      // Unmapped or unaligned addresses answer with an error
      if (psel && pen && pready === 1'b1)
         check(pslverr, (paddr[1:0] != 2'b00) || (paddr > OFF_INSTR)); // bus error
      if (psel && pen && pready === 1'b1 && !pwr)
         check(prdata, rq.pop_front()); // read value
   end
   // Watchdog
   initial
   begin
      repeat (8000) @(posedge clk);
      fails++;
      stop_test();
   end
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(OFF_CTRL, 32'h0000_0000); // enable off
      rd(8'h18, 32'h0000_0000); // unmapped reads zero
      begin : wr_regs
         apb(1'b1, OFF_BASE, 32'h0000_0A00);
         apb(1'b1, OFF_BANK, 32'h0000_0005);
      end
      run({8'h68, 8'h20}, 12'h020, SET_ALL, 1'b1); // access low
      run({8'h69, 8'h33}, 12'h533, SET_ALL, 1'b1); // banked
      run({8'h68, 8'h80}, 12'hF80, SET_ALL, 1'b1); // access high
      apb(1'b1, OFF_CTRL, 32'h0000_0001); // enable set
      run({8'h68, 8'h60}, 12'hF60, SET_ALL, 1'b1); // above limit
      run({8'h69, 8'h10}, 12'h510, SET_ALL, 1'b1); // banked
      for (int i = 0; i < 12; i++)
      begin
         k = (i == 0) ? 8'h5F : (i == 1) ? 8'h00 : 8'(rnd() % 96);
         base = (i == 2) ? 12'hFF0 : 12'(rnd());
         m = 8'(rnd());
         b = 3'(i);
         ea = 12'(base + {4'h0, k});
         acc = 8'(rnd());
         apb(1'b1, OFF_BASE, {20'h0_0000, base});
         apb(1'b1, OFF_ACC, {24'h00_0000, acc});
         mem_i.mem[ea] = m;
         addx(m, s);
         run({6'h09, 1'b1, 1'b0, k}, ea, s, 1'b1); // sum to memory
         rd(OFF_STATUS, {27'h0, flg}); // flags
         run({4'h8, b, 1'b0, k}, ea, s | (8'h01 << b), 1'b1); // bit set
         run({8'h68, k}, ea, SET_ALL, 1'b1); // all ones
         rd(OFF_STATUS, {27'h0, flg}); // flags kept
         addx(SET_ALL, s);
         run({6'h09, 1'b0, 1'b0, k}, ea, 8'h00, 1'b0); // to accumulator
         acc = s;
         rd(OFF_ACC, {24'h00_0000, acc}); // accumulator
         rd(OFF_BASE, {20'h0_0000, base}); // pointer kept
      end
      // Bus write while busy must wait until the instruction ends
      apb(1'b1, OFF_INSTR, 32'h0000_6940);
      wq.push_back('{12'h540, SET_ALL, cyc + 4});
      t0 = cyc;
      apb(1'b1, OFF_ACC, 32'h0000_005A);
      check(cyc - t0, 5); // write stalled
      rd(OFF_ACC, 32'h0000_005A); // accumulator written
      repeat (4) @(posedge clk);
      check(wq.size(), 0); // all writes seen
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
